// ===== include/ip_pos_pkg.sv
// Package: register map, field positions, reset values and timing for interpolated position
package ip_pos_pkg;

  // ********************************
  // Timing
  // ********************************
  localparam int unsigned CLK_FREQ_HZ     = 40000000;
  localparam int unsigned SUBSTEP_US      = 250;
  localparam int unsigned SUBSTEP_CYCLES  = (CLK_FREQ_HZ / 1000000) * SUBSTEP_US;
  localparam int unsigned MS_US           = 1000;
  localparam int unsigned STEPS_PER_MS    = MS_US / SUBSTEP_US;
  localparam int unsigned CYCLE_MS_MIN    = 1;
  localparam int unsigned CYCLE_MS_MAX    = 20;

  // ********************************
  // Register offsets (byte addresses)
  // ********************************
  localparam logic [7:0] ADDR_CONTROL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS      = 8'h04;
  localparam logic [7:0] ADDR_REF_POS     = 8'h08;
  localparam logic [7:0] ADDR_CYCLE_TIME  = 8'h0C;
  localparam logic [7:0] ADDR_SYNC_TOL    = 8'h10;
  localparam logic [7:0] ADDR_OPTIONS     = 8'h14;
  localparam logic [7:0] ADDR_INTERP_POS  = 8'h18;

  // ********************************
  // Field positions
  // ********************************
  localparam int unsigned CW_HALT_BIT      = 8;
  localparam int unsigned CW_QSTOP_N_BIT   = 2;
  localparam int unsigned CW_ENABLE_BIT    = 3;
  localparam int unsigned CW_MODE_BIT      = 4;
  localparam int unsigned SW_FAULT_BIT     = 3;
  localparam int unsigned SW_MODE_BIT      = 12;
  localparam int unsigned OPT_LIMSUP_BIT   = 0;
  localparam int unsigned OPT_SDO_BIT      = 1;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [15:0] CONTROL_RST     = 16'h0000;
  localparam logic [4:0]  CYCLE_MS_RST    = 5'h02;
  localparam logic [4:0]  SYNC_TOL_RST    = 5'h01;
  localparam logic [1:0]  OPTIONS_RST     = 2'h0;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_WAIT = 2'b01,
    MODE_RUN  = 2'b10
  } mode_state_t;

endpackage

// ===== src/step_divider.sv
// Even distribution of a position step across the sub-steps of one cycle
`timescale 1ns/100ps
module step_divider
  import ip_pos_pkg::*;
#(
  parameter int unsigned POS_W = 32
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Request
  input  wire logic              start,
  input  wire logic [POS_W-1:0]  fromPos,
  input  wire logic [POS_W-1:0]  toPos,
  input  wire logic [6:0]        steps,
  input  wire logic              advance,
  // Result
  output logic [POS_W-1:0]       position
);

  logic [POS_W-1:0] pos_ff, nxt_pos;
  logic [POS_W-1:0] base_ff, nxt_base;
  logic [POS_W:0]   delta_ff, nxt_delta;
  logic [6:0]       idx_ff, nxt_idx;
  logic [6:0]       cnt_ff, nxt_cnt;
  logic signed [POS_W+8:0] prod;

  assign position = pos_ff;

  always_comb begin
    nxt_pos   = pos_ff;
    nxt_base  = base_ff;
    nxt_delta = delta_ff;
    nxt_idx   = idx_ff;
    nxt_cnt   = cnt_ff;
    prod      = '0;
    if (start) begin
      nxt_base  = fromPos;
      nxt_delta = {toPos[POS_W-1], toPos} - {fromPos[POS_W-1], fromPos};
      nxt_idx   = 7'h00;
      nxt_cnt   = (steps == 7'h00) ? 7'h01 : steps;
    end else if (advance && idx_ff < cnt_ff) begin
      // Linear share of the step; last sub-step lands exactly on target
      nxt_idx = idx_ff + 7'h01;
      prod    = $signed(delta_ff) * $signed({2'b00, nxt_idx});
      nxt_pos = base_ff + POS_W'(prod / $signed({34'h0, cnt_ff}));
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pos_ff   <= '0;
      base_ff  <= '0;
      delta_ff <= '0;
      idx_ff   <= 7'h00;
      cnt_ff   <= 7'h01;
    end else begin
      pos_ff   <= nxt_pos;
      base_ff  <= nxt_base;
      delta_ff <= nxt_delta;
      idx_ff   <= nxt_idx;
      cnt_ff   <= nxt_cnt;
    end
  end

endmodule

// ===== src/interpolated_position_mode.sv
// Interpolated position mode: setpoint latch, SYNC start, 250 us fine interpolation, APB registers
//
// What this block does
// - Follow a new reference position every cycle
// - Cycle period configurable 1 to 20 ms
// - Movement starts on SYNC, not on setpoint
// - Interpolated position updated every 250 us
// - No heartbeat or guarding in this mode
// - Limit-switch errors suppressed when option set and power stage enabled
// - Control bit 4 starts and ends mode
// - Service-data control starts on bit-4 rising edge
// - Status bit 12 shows mode running
// - Terminate on bit 4 clear, halt, stop, error
// - Sync tolerance counted in 250 us units
`timescale 1ns/100ps
module interpolated_position_mode
  import ip_pos_pkg::*;
#(
  parameter int unsigned POS_W = 32
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Fieldbus events and drive pins
  input  wire logic              syncPulse,
  input  wire logic              positive_limit_input,
  input  wire logic              negative_limit_input,
  input  wire logic              driveError,
  // Motion outputs
  output logic [POS_W-1:0]       interpPosition,
  output logic                   modeActive,
  output logic                   syncLost,
  output logic                   limitFault,
  output logic                   linkMonitorEnable
);

  // Elaboration-time guard on the position width
  if (POS_W < 8 || POS_W > 32) begin : g_bad_width
    $error("POS_W must be 8..32");
  end

  // ********************************
  // Input synchronisers
  // ********************************
  logic [3:0] meta_ff, sync_ff, prev_ff;
  logic       syncRise;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_ff <= 4'h0;
      sync_ff <= 4'h0;
      prev_ff <= 4'h0;
    end else begin
      meta_ff <= {driveError, negative_limit_input, positive_limit_input, syncPulse};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end
  assign syncRise = sync_ff[0] & ~prev_ff[0];

  // ********************************
  // Registers and APB
  // ********************************
  logic [15:0]      drive_control_word_ff, nxt_drive_control_word;
  logic [POS_W-1:0] refPos_ff, nxt_refPos;
  logic [4:0]       cycleMs_ff, nxt_cycleMs;
  logic [4:0]       sync_tolerance_setting_ff, nxt_sync_tolerance_setting;
  logic [1:0]       options_ff, nxt_options;
  logic             wrEn, rdEn, badAddr, badData;
  logic [31:0]      nxt_prdata, prdata_ff;
  logic [15:0]      drive_status_word;

  assign wrEn    = psel & penable & pwrite;
  assign rdEn    = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  always_comb begin
    badAddr = 1'b0;
    badData = 1'b0;
    case (paddr)
      ADDR_CONTROL, ADDR_STATUS, ADDR_REF_POS, ADDR_OPTIONS, ADDR_INTERP_POS: badAddr = 1'b0;
      ADDR_CYCLE_TIME: badData = pwrite && (pwdata[4:0] < 5'(CYCLE_MS_MIN) || pwdata[4:0] > 5'(CYCLE_MS_MAX)
                                            || pwdata[31:5] != '0);
      ADDR_SYNC_TOL:   badData = pwrite && (pwdata[4:0] == 5'h00 || pwdata[4:0] > 5'h14 || pwdata[31:5] != '0);
      default: badAddr = 1'b1;
    endcase
  end
  assign pslverr = psel & penable & (badAddr | badData);

  always_comb begin
    nxt_drive_control_word     = drive_control_word_ff;
    nxt_refPos                 = refPos_ff;
    nxt_cycleMs                = cycleMs_ff;
    nxt_sync_tolerance_setting = sync_tolerance_setting_ff;
    nxt_options                = options_ff;
    nxt_prdata                 = prdata_ff;
    if (wrEn && !badData) begin
      case (paddr)
        ADDR_CONTROL:    nxt_drive_control_word = pwdata[15:0];
        ADDR_REF_POS:    nxt_refPos = pwdata[POS_W-1:0];
        ADDR_CYCLE_TIME: nxt_cycleMs = pwdata[4:0];
        ADDR_SYNC_TOL:   nxt_sync_tolerance_setting = pwdata[4:0];
        ADDR_OPTIONS:    nxt_options = pwdata[1:0];
        default:         nxt_options = options_ff;
      endcase
    end
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CONTROL:    nxt_prdata = {16'h0000, drive_control_word_ff};
        ADDR_STATUS:     nxt_prdata = {16'h0000, drive_status_word};
        ADDR_REF_POS:    nxt_prdata = 32'(signed'(refPos_ff));
        ADDR_CYCLE_TIME: nxt_prdata = {27'h0, cycleMs_ff};
        ADDR_SYNC_TOL:   nxt_prdata = {27'h0, sync_tolerance_setting_ff};
        ADDR_OPTIONS:    nxt_prdata = {30'h0, options_ff};
        ADDR_INTERP_POS: nxt_prdata = 32'(signed'(interpPosition));
        default:         nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      drive_control_word_ff     <= CONTROL_RST;
      refPos_ff                 <= '0;
      cycleMs_ff                <= CYCLE_MS_RST;
      sync_tolerance_setting_ff <= SYNC_TOL_RST;
      options_ff                <= OPTIONS_RST;
      prdata_ff                 <= 32'h0000_0000;
    end else begin
      drive_control_word_ff     <= nxt_drive_control_word;
      refPos_ff                 <= nxt_refPos;
      cycleMs_ff                <= nxt_cycleMs;
      sync_tolerance_setting_ff <= nxt_sync_tolerance_setting;
      options_ff                <= nxt_options;
      prdata_ff                 <= nxt_prdata;
    end
  end
  assign prdata = prdata_ff;

  // ********************************
  // Mode control
  // ********************************
  mode_state_t state_ff, nxt_state;
  logic        bit4Prev_ff, nxt_bit4Prev;
  logic        bit4, bit4Rise, stopReq, errNow;
  logic [POS_W-1:0] lastTarget_ff, nxt_lastTarget;
  logic        startSeg, subTick;
  // Wide enough to hold the full 10000-cycle sub-step
  logic [13:0] subCnt_ff, nxt_subCnt;
  logic [6:0]  gapCnt_ff, nxt_gapCnt;
  logic        syncLost_ff, nxt_syncLost;
  logic [6:0]  stepsPerCycle, tolSteps;

  assign bit4 = drive_control_word_ff[CW_MODE_BIT];
  assign bit4Rise = bit4 & ~bit4Prev_ff;
  // Suppression option masks limit faults while power stage enabled
  assign limitFault = (sync_ff[1] | sync_ff[2]) &
                      ~(options_ff[OPT_LIMSUP_BIT] & drive_control_word_ff[CW_ENABLE_BIT]);
  assign errNow  = sync_ff[3] | limitFault | syncLost_ff;
  assign stopReq = drive_control_word_ff[CW_HALT_BIT] | ~drive_control_word_ff[CW_QSTOP_N_BIT];
  assign stepsPerCycle = 7'(cycleMs_ff * STEPS_PER_MS);
  assign tolSteps      = 7'(sync_tolerance_setting_ff);
  assign subTick  = (subCnt_ff == 14'(SUBSTEP_CYCLES - 1));
  // The first SYNC after start already launches a segment
  assign startSeg = (state_ff != MODE_IDLE) & syncRise;

  always_comb begin
    nxt_state      = state_ff;
    nxt_bit4Prev   = bit4;
    nxt_lastTarget = lastTarget_ff;
    nxt_subCnt     = subTick ? 14'h0000 : subCnt_ff + 14'h0001;
    nxt_gapCnt     = gapCnt_ff;
    nxt_syncLost   = syncLost_ff;
    case (state_ff)
      MODE_IDLE: begin
        nxt_lastTarget = interpPosition;
        // Overdue-SYNC fault held until bit 4 drops, so a lost link cannot restart itself
        if (!bit4) nxt_syncLost = 1'b0;
        // Service-data path needs power stage and a fresh edge
        if (!errNow && !stopReq && (options_ff[OPT_SDO_BIT] ?
            (bit4Rise && drive_control_word_ff[CW_ENABLE_BIT]) : bit4)) begin
          nxt_state    = MODE_WAIT;
          nxt_syncLost = 1'b0;
        end
      end
      MODE_WAIT, MODE_RUN: begin
        if (syncRise) begin
          nxt_state      = MODE_RUN;
          nxt_lastTarget = refPos_ff;
          nxt_gapCnt     = 7'h00;
          nxt_subCnt     = 14'h0000;
        end else if (state_ff == MODE_RUN && subTick) begin
          nxt_gapCnt = gapCnt_ff + 7'h01;
          // SYNC overdue by more than the tolerance
          if (gapCnt_ff >= stepsPerCycle + tolSteps - 7'h01) nxt_syncLost = 1'b1;
        end
        if (!bit4 || stopReq || errNow) nxt_state = MODE_IDLE;
      end
      default: nxt_state = MODE_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff      <= MODE_IDLE;
      bit4Prev_ff   <= 1'b0;
      lastTarget_ff <= '0;
      subCnt_ff     <= 14'h0000;
      gapCnt_ff     <= 7'h00;
      syncLost_ff   <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      bit4Prev_ff   <= nxt_bit4Prev;
      lastTarget_ff <= nxt_lastTarget;
      subCnt_ff     <= nxt_subCnt;
      gapCnt_ff     <= nxt_gapCnt;
      syncLost_ff   <= nxt_syncLost;
    end
  end

  assign modeActive = (state_ff != MODE_IDLE);
  assign syncLost   = syncLost_ff;
  // Heartbeat and guarding off while mode runs
  assign linkMonitorEnable = ~modeActive;
  always_comb begin
    drive_status_word = 16'h0000;
    drive_status_word[SW_MODE_BIT]  = modeActive;
    drive_status_word[SW_FAULT_BIT] = errNow;
  end

  // ********************************
  // Fine interpolator
  // ********************************
  step_divider #(
    .POS_W (POS_W)
  ) u_step (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .start    (startSeg),
    .fromPos  (lastTarget_ff),
    .toPos    (refPos_ff),
    .steps    (stepsPerCycle),
    .advance  (subTick & (state_ff == MODE_RUN)),
    .position (interpPosition)
  );

endmodule

// ===== tb/ip_pos_assertions.sv
// Checker: port-level assertions for the interpolated position mode block
`timescale 1ns/100ps
module ip_pos_checker
  import ip_pos_pkg::*;
#(
  parameter int unsigned POS_W = 32
) (
  // Clock and reset
  input wire logic             core_clk,
  input wire logic             rst_n,
  // APB slave
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // Fieldbus events and drive pins
  input wire logic             syncPulse,
  input wire logic             positive_limit_input,
  input wire logic             negative_limit_input,
  input wire logic             driveError,
  // Motion outputs
  input wire logic [POS_W-1:0] interpPosition,
  input wire logic             modeActive,
  input wire logic             syncLost,
  input wire logic             limitFault,
  input wire logic             linkMonitorEnable
);
  logic             wrAcc;
  logic             ctlWr;
  logic [15:0]      gap_ff;
  logic [15:0]      nxt_gap;
  logic [POS_W-1:0] lastPos_ff;

  assign wrAcc = psel && penable && pwrite;
  assign ctlWr = wrAcc && (paddr == ADDR_CONTROL);

  // Cycles since the position last moved; saturates so idle spells never wrap
  always_comb begin
    if (interpPosition != lastPos_ff) begin
      nxt_gap = 16'h0000;
    end else begin
      nxt_gap = (gap_ff == 16'hFFFF) ? gap_ff : gap_ff + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gap_ff     <= 16'h0000;
      lastPos_ff <= '0;
    end else begin
      gap_ff     <= nxt_gap;
      lastPos_ff <= interpPosition;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_link_mon: assert property (linkMonitorEnable == !modeActive)
    else $error("link monitor enable does not mirror the mode");
  a_mode_stop: assert property (ctlWr && !pwdata[CW_MODE_BIT] |-> ##[1:2] !modeActive)
    else $error("mode still running after start bit cleared");
  a_halt_stop: assert property (ctlWr && pwdata[CW_HALT_BIT] |-> ##[1:2] !modeActive)
    else $error("mode still running after halt");
  a_qstop_stop: assert property (ctlWr && !pwdata[CW_QSTOP_N_BIT] |-> ##[1:2] !modeActive)
    else $error("mode still running after quick stop");
  a_error_stop: assert property (driveError [*4] |-> ##[0:3] !modeActive)
    else $error("mode still running with drive error");
  a_step_gap: assert property (interpPosition != lastPos_ff |-> gap_ff >= SUBSTEP_CYCLES - 1)
    else $error("interpolated position moved before the sub-step ended");
  a_cycle_range: assert property (wrAcc && paddr == ADDR_CYCLE_TIME && (pwdata == 0 || pwdata > 20) |-> pslverr)
    else $error("cycle time outside range accepted");
  a_tol_range: assert property (wrAcc && paddr == ADDR_SYNC_TOL && (pwdata == 0 || pwdata > 20) |-> pslverr)
    else $error("sync tolerance outside range accepted");
endmodule

bind interpolated_position_mode ip_pos_checker #(.POS_W(POS_W)) i_chk (.*);

// ===== tb/host_sync.sv
// Host-side SYNC source: stretches each request into a SYNC pulse on the bus pin
`timescale 1ns/100ps
module host_sync
  import ip_pos_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Request and pin
  input  wire logic fire,
  output logic      syncPulse
);
  logic [1:0] hold_ff;
  logic [1:0] nxt_hold;

  // Three clocks high so the drive's two-flop synchroniser cannot miss it
  always_comb begin
    if (fire) begin
      nxt_hold = 2'h3;
    end else begin
      nxt_hold = (hold_ff != 2'h0) ? hold_ff - 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    hold_ff <= rst_n ? nxt_hold : 2'h0;
  end

  assign syncPulse = (hold_ff != 2'h0);
endmodule

// ===== tb/tb_interpolated_position_mode.sv
// Testbench: interpolated position mode over APB with a host SYNC source
`timescale 1ns/100ps
module tb_interpolated_position_mode import ip_pos_pkg::*;;
  logic        core_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        syncPulse;
  logic        fire;
  logic        positive_limit_input;
  logic        negative_limit_input;
  logic        driveError;
  logic [31:0] interpPosition;
  logic        modeActive;
  logic        syncLost;
  logic        limitFault;
  logic        linkMonitorEnable;
  logic [31:0] refPos;
  logic [31:0] rdVal;
  logic        rdErr;
  int          fails;
  int          checks;
  int          cyc;

  interpolated_position_mode #(.POS_W(32)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .syncPulse(syncPulse), .positive_limit_input(positive_limit_input),
    .negative_limit_input(negative_limit_input), .driveError(driveError), .interpPosition(interpPosition),
    .modeActive(modeActive), .syncLost(syncLost), .limitFault(limitFault),
    .linkMonitorEnable(linkMonitorEnable));
  host_sync i_host (.core_clk(core_clk), .rst_n(rst_n), .fire(fire), .syncPulse(syncPulse));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic close_out;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Whole run is about 62k cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fails++;
      close_out;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic chkB(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdVal = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdVal, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic ctl(input logic [15:0] v, input logic expAct);
    apb(1'b1, ADDR_CONTROL, {16'h0, v});
    settle(2);
    chkB(modeActive, expAct);
  endtask

  function automatic logic [31:0] segPos(input logic [31:0] target, input int k, input int n);
    return target * k / n;
  endfunction

  initial begin
    {rst_n, psel, penable, pwrite, fire, driveError} = 6'h00;
    {positive_limit_input, negative_limit_input} = 2'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cyc = 0;
    void'($urandom(32'h3AE3));
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(ADDR_CONTROL, {16'h0, CONTROL_RST});
    rd(ADDR_CYCLE_TIME, {27'h0, CYCLE_MS_RST});
    rd(ADDR_SYNC_TOL, {27'h0, SYNC_TOL_RST});
    rd(ADDR_STATUS, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chkB(rdErr, 1'b1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, (i < 2) ? ADDR_CYCLE_TIME : ADDR_SYNC_TOL, i[0] ? 32'h15 : 32'h0);
      chkB(rdErr, 1'b1);
    end
    apb(1'b1, ADDR_CYCLE_TIME, 32'h1);
    apb(1'b1, ADDR_SYNC_TOL, 32'h14);
    rd(ADDR_CYCLE_TIME, 32'h1);
    rd(ADDR_SYNC_TOL, 32'h14);
    // Tightest tolerance keeps the overdue-SYNC test short
    apb(1'b1, ADDR_SYNC_TOL, 32'h1);
    positive_limit_input <= 1'b1;
    negative_limit_input <= 1'b1;
    settle(4);
    chkB(limitFault, 1'b1);
    apb(1'b1, ADDR_OPTIONS, 32'h1);
    ctl(16'h000C, 1'b0);
    chkB(limitFault, 1'b0);
    rd(ADDR_OPTIONS, 32'h1);
    positive_limit_input <= 1'b0;
    negative_limit_input <= 1'b0;
    apb(1'b1, ADDR_OPTIONS, 32'h0);
    refPos = 32'($urandom_range(1, 4096)) * 32'h4;
    apb(1'b1, ADDR_REF_POS, refPos);
    rd(ADDR_REF_POS, refPos);
    ctl(16'h0014, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chkB(rdVal[SW_MODE_BIT], 1'b1);
    chkB(linkMonitorEnable, 1'b0);
    settle(12000);
    chk(interpPosition, 32'h0);
    @(posedge core_clk);
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    repeat (5000) @(posedge core_clk);
    // Sample mid sub-step, clear of the SYNC latency
    for (int k = 1; k <= STEPS_PER_MS; k++) begin
      settle(9999);
      chk(interpPosition, segPos(refPos, k, STEPS_PER_MS));
    end
    // No further SYNC: overdue after one cycle plus one tolerance step
    chkB(syncLost, 1'b0);
    settle(5010);
    chkB(syncLost, 1'b1);
    chkB(modeActive, 1'b0);
    rd(ADDR_STATUS, 32'h1 << SW_FAULT_BIT);
    rd(ADDR_INTERP_POS, refPos);
    ctl(16'h0004, 1'b0);
    chkB(linkMonitorEnable, 1'b1);
    chkB(syncLost, 1'b0);
    ctl(16'h0014, 1'b1);
    ctl(16'h0114, 1'b0);
    ctl(16'h0014, 1'b1);
    ctl(16'h0010, 1'b0);
    ctl(16'h0014, 1'b1);
    @(posedge core_clk);
    driveError <= 1'b1;
    settle(6);
    chkB(modeActive, 1'b0);
    @(posedge core_clk);
    driveError <= 1'b0;
    ctl(16'h0000, 1'b0);
    apb(1'b1, ADDR_OPTIONS, 32'h2);
    rd(ADDR_OPTIONS, 32'h2);
    ctl(16'h0014, 1'b0);
    ctl(16'h001C, 1'b0);
    ctl(16'h000C, 1'b0);
    ctl(16'h001C, 1'b1);
    close_out;
  end
endmodule
